/* File: src/hbr_host_bus.sv */
// host bus burst master with clock-run request and boot rom port
`timescale 1ns/100ps
`default_nettype none
`include "hbr_params.svh"

module hbr_host_bus (
   input  wire logic                  clock,
   input  wire logic                  rst,
   input  wire logic                  xfer_valid,
   input  wire hbr_pkg::hbr_xfer_t    xfer,
   output logic                       xfer_ready,
   input  wire logic [31:0]           wr_data,
   output logic                       wr_take,
   output logic [31:0]                rd_data,
   output logic                       rd_valid,
   output logic                       xfer_done,
   output logic                       xfer_abort,
   input  wire logic                  rom_req_valid,
   input  wire hbr_pkg::hbr_rom_req_t rom_req,
   output logic                       rom_req_ready,
   output logic [7:0]                 rom_rd_data,
   output logic                       rom_done,
   input  wire logic [31:0]           pci_ad_in,
   output logic [31:0]                pci_ad_out,
   output logic                       pci_ad_oe_n,
   output logic [3:0]                 pci_cbe_n_out,
   output logic                       pci_cbe_oe_n,
   output logic                       pci_frame_n_out,
   output logic                       pci_irdy_n_out,
   output logic                       pci_ctl_oe_n,
   input  wire logic                  pci_trdy_n,
   input  wire logic                  pci_devsel_n,
   output logic                       pci_req_n,
   input  wire logic                  pci_gnt_n,
   input  wire logic                  clkrun_in_n,
   output logic                       clkrun_out,
   output logic                       clkrun_oe_n,
   input  wire logic [7:0]            rom_mux_in,
   output logic [7:0]                 rom_mux_addr_data,
   output logic                       rom_mux_oe_n,
   output logic                       rom_addr_latch_strobe,
   input  wire logic                  rom_addr_bit0_in,
   output logic                       rom_addr_bit0_out,
   output logic                       rom_addr_bit0_oe_n,
   output logic                       rom_chip_enable_n,
   output logic                       card_signalling_select_n
);

   typedef enum logic [2:0] {HBR_IDLE, HBR_REQ, HBR_ADDR, HBR_DATA, HBR_TURN} hbr_bus_st_t;

   // big endian swaps byte lanes of every data word
   function automatic logic [31:0] hbr_swap(input logic [31:0] d, input logic big);
      hbr_swap = big ? {d[7:0], d[15:8], d[23:16], d[31:24]} : d;
   endfunction

   hbr_bus_st_t        st_ff, nxt_st;
   hbr_pkg::hbr_xfer_t x_ff, nxt_x;
   logic [7:0]         cnt_ff, nxt_cnt;
   logic [2:0]         dto_ff, nxt_dto;
   logic [31:0]        ad_ff, nxt_ad, rd_ff, nxt_rd;
   logic [3:0]         cbe_ff, nxt_cbe, be_eff;
   logic               adoe_ff, nxt_adoe, cbeoe_ff, nxt_cbeoe, frame_ff, nxt_frame;
   logic               irdy_ff, nxt_irdy, ctloe_ff, nxt_ctloe, req_ff, nxt_req;
   logic               rv_ff, nxt_rv, done_ff, nxt_done, abort_ff, nxt_abort;
   logic               ckr_ff, nxt_ckr, beat, rom_busy, need_clk;

   // ****************************************
   // burst master
   // ****************************************
   always_comb begin
      nxt_st    = st_ff;
      nxt_x     = x_ff;
      nxt_cnt   = cnt_ff;
      nxt_dto   = dto_ff;
      nxt_ad    = ad_ff;
      nxt_adoe  = adoe_ff;
      nxt_cbe   = cbe_ff;
      nxt_cbeoe = cbeoe_ff;
      nxt_frame = frame_ff;
      nxt_irdy  = irdy_ff;
      nxt_ctloe = ctloe_ff;
      nxt_req   = req_ff;
      nxt_rd    = rd_ff;
      nxt_rv    = 1'b0;
      nxt_done  = 1'b0;
      nxt_abort = 1'b0;
      wr_take   = 1'b0;
      // lane n enable follows byte n after any swap
      be_eff    = x_ff.big_endian ? {x_ff.be[0], x_ff.be[1], x_ff.be[2], x_ff.be[3]} : x_ff.be;
      beat      = (st_ff == HBR_DATA) && !irdy_ff && !pci_trdy_n && !pci_devsel_n;
      unique case (st_ff)
         HBR_IDLE: if (xfer_valid) begin
            nxt_x   = xfer;
            nxt_cnt = (xfer.len == 8'h00) ? 8'h01 : xfer.len;
            nxt_req = 1'b0;
            nxt_st  = HBR_REQ;
         end
         HBR_REQ: if (!pci_gnt_n) begin
            nxt_ad    = x_ff.addr;
            nxt_adoe  = 1'b0;
            nxt_cbe   = x_ff.write ? `HBR_CMD_MEM_WR : `HBR_CMD_MEM_RD;
            nxt_cbeoe = 1'b0;
            nxt_frame = 1'b0;
            nxt_ctloe = 1'b0;
            nxt_req   = 1'b1;
            nxt_st    = HBR_ADDR;
         end
         HBR_ADDR: begin
            nxt_irdy  = 1'b0;
            nxt_frame = (cnt_ff == 8'h01);
            nxt_cbe   = ~be_eff;
            nxt_dto   = 3'h0;
            if (x_ff.write) begin
               nxt_ad  = hbr_swap(wr_data, x_ff.big_endian);
               wr_take = 1'b1;
            end else begin
               nxt_adoe = 1'b1;
            end
            nxt_st = HBR_DATA;
         end
         HBR_DATA: if (beat) begin
            if (!x_ff.write) begin
               nxt_rd = hbr_swap(pci_ad_in, x_ff.big_endian);
               nxt_rv = 1'b1;
            end
            if (cnt_ff == 8'h01) begin
               nxt_frame = 1'b1;
               nxt_irdy  = 1'b1;
               nxt_adoe  = 1'b1;
               nxt_cbeoe = 1'b1;
               nxt_done  = 1'b1;
               nxt_st    = HBR_TURN;
            end else begin
               nxt_cnt   = cnt_ff - 8'h01;
               // frame lifts for the final data phase
               nxt_frame = (cnt_ff == 8'h02);
               if (x_ff.write) begin
                  nxt_ad  = hbr_swap(wr_data, x_ff.big_endian);
                  wr_take = 1'b1;
               end
            end
         end else if (pci_devsel_n) begin
            // no target claimed the cycle: give the bus back
            if (dto_ff == `HBR_DEVSEL_TO - 3'h1) begin
               nxt_frame = 1'b1;
               nxt_irdy  = 1'b1;
               nxt_adoe  = 1'b1;
               nxt_cbeoe = 1'b1;
               nxt_abort = 1'b1;
               nxt_st    = HBR_TURN;
            end else begin
               nxt_dto = dto_ff + 3'h1;
            end
         end
         HBR_TURN: begin
            // controls driven high one cycle before release
            nxt_ctloe = 1'b1;
            nxt_st    = HBR_IDLE;
         end
      endcase
   end

   // ****************************************
   // clock-run request
   // ****************************************
   // pull once the host lets go, then hold: our own pull hides the host's level
   assign need_clk = (st_ff != HBR_IDLE) || xfer_valid || rom_busy || rom_req_valid;
   always_comb begin
      nxt_ckr = ~(need_clk && (clkrun_in_n || !ckr_ff));
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         st_ff    <= HBR_IDLE;
         x_ff     <= '0;
         cnt_ff   <= 8'h00;
         dto_ff   <= 3'h0;
         ad_ff    <= `HBR_AD_RST;
         rd_ff    <= `HBR_AD_RST;
         cbe_ff   <= 4'hF;
         adoe_ff  <= 1'b1;
         cbeoe_ff <= 1'b1;
         frame_ff <= 1'b1;
         irdy_ff  <= 1'b1;
         ctloe_ff <= 1'b1;
         req_ff   <= 1'b1;
         rv_ff    <= 1'b0;
         done_ff  <= 1'b0;
         abort_ff <= 1'b0;
         ckr_ff   <= 1'b1;
      end else begin
         st_ff    <= nxt_st;
         x_ff     <= nxt_x;
         cnt_ff   <= nxt_cnt;
         dto_ff   <= nxt_dto;
         ad_ff    <= nxt_ad;
         rd_ff    <= nxt_rd;
         cbe_ff   <= nxt_cbe;
         adoe_ff  <= nxt_adoe;
         cbeoe_ff <= nxt_cbeoe;
         frame_ff <= nxt_frame;
         irdy_ff  <= nxt_irdy;
         ctloe_ff <= nxt_ctloe;
         req_ff   <= nxt_req;
         rv_ff    <= nxt_rv;
         done_ff  <= nxt_done;
         abort_ff <= nxt_abort;
         ckr_ff   <= nxt_ckr;
      end
   end

   assign xfer_ready      = (st_ff == HBR_IDLE);
   assign rd_data         = rd_ff;
   assign rd_valid        = rv_ff;
   assign xfer_done       = done_ff;
   assign xfer_abort      = abort_ff;
   assign pci_ad_out      = ad_ff;
   assign pci_ad_oe_n     = adoe_ff;
   assign pci_cbe_n_out   = cbe_ff;
   assign pci_cbe_oe_n    = cbeoe_ff;
   assign pci_frame_n_out = frame_ff;
   assign pci_irdy_n_out  = irdy_ff;
   assign pci_ctl_oe_n    = ctloe_ff;
   assign pci_req_n       = req_ff;
   assign clkrun_out      = 1'b0;
   assign clkrun_oe_n     = ckr_ff;

   // ****************************************
   // boot rom port
   // ****************************************
   hbr_rom_port u_rom (
      .clock                    (clock),
      .rst                      (rst),
      .req_valid                (rom_req_valid),
      .req                      (rom_req),
      .req_ready                (rom_req_ready),
      .busy                     (rom_busy),
      .rd_data                  (rom_rd_data),
      .done                     (rom_done),
      .rom_mux_in               (rom_mux_in),
      .rom_mux_addr_data        (rom_mux_addr_data),
      .rom_mux_oe_n             (rom_mux_oe_n),
      .rom_addr_latch_strobe    (rom_addr_latch_strobe),
      .rom_addr_bit0_in         (rom_addr_bit0_in),
      .rom_addr_bit0_out        (rom_addr_bit0_out),
      .rom_addr_bit0_oe_n       (rom_addr_bit0_oe_n),
      .rom_chip_enable_n        (rom_chip_enable_n),
      .card_signalling_select_n (card_signalling_select_n)
   );

   // ****************************************
   // checks
   // ****************************************
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);

   a_addr_phase_cmd: assert property ($fell(frame_ff) |-> !adoe_ff && ad_ff == x_ff.addr
      && cbe_ff == (x_ff.write ? `HBR_CMD_MEM_WR : `HBR_CMD_MEM_RD))
      else $error("address phase content wrong");
   a_data_follows: assert property ($fell(frame_ff) |=> !irdy_ff)
      else $error("no data phase after address");
   a_master_only: assert property ($fell(frame_ff) |-> $past(!pci_gnt_n) && $past(!req_ff))
      else $error("bus driven without grant");
   a_byte_enables: assert property (!irdy_ff |-> cbe_ff == ~be_eff && !cbeoe_ff)
      else $error("byte enables wrong in data phase");
   a_read_swap: assert property (beat && !x_ff.write |=> rv_ff
      && rd_ff == hbr_swap($past(pci_ad_in), x_ff.big_endian))
      else $error("read data byte order wrong");
   a_write_word: assert property ($rose(wr_take) && st_ff == HBR_ADDR
      |=> ad_ff == hbr_swap($past(wr_data), x_ff.big_endian))
      else $error("write data not presented");
   a_clkrun_request: assert property (need_clk && (clkrun_in_n || !ckr_ff) |=> !ckr_ff)
      else $error("clock-run not requested");
   a_clkrun_release: assert property (!need_clk |=> ckr_ff)
      else $error("clock-run held while idle");
   a_devsel_abort: assert property (st_ff == HBR_DATA && pci_devsel_n [*5] |=> abort_ff)
      else $error("missing target not aborted");

   c_write_burst: cover property (x_ff.write && beat ##1 beat ##[1:8] done_ff);
   c_read_burst: cover property (!x_ff.write && beat ##1 beat ##[1:8] done_ff);
   c_abort: cover property (abort_ff);
endmodule // hbr_host_bus

`default_nettype wire

/* File: src/hbr_params.svh */
// constants for the host bus and boot rom port
`ifndef HBR_PARAMS_SVH
`define HBR_PARAMS_SVH

// ****************************************
// bus commands driven in the address phase
// ****************************************
`define HBR_CMD_MEM_RD 4'h6
`define HBR_CMD_MEM_WR 4'h7

// ****************************************
// timing counts in bus clock cycles
// ****************************************
`define HBR_DEVSEL_TO 3'h5
`define HBR_ROM_DATA_CYC 2'h3

// ****************************************
// reset values
// ****************************************
`define HBR_AD_RST 32'h0000_0000
`define HBR_ROM_MUX_RST 8'h00

`endif

/* File: src/hbr_pkg.sv */
// types shared by the host bus master and the boot rom port
package hbr_pkg;

   // one burst request from the user side
   typedef struct packed {
      logic [31:0] addr;
      logic        write;
      logic [7:0]  len;
      logic [3:0]  be;
      logic        big_endian;
   } hbr_xfer_t;

   // one boot rom or external register access
   typedef struct packed {
      logic [17:0] addr;
      logic        write;
      logic [7:0]  wdata;
   } hbr_rom_req_t;

endpackage

/* File: src/hbr_rom_port.sv */
// boot rom port: two latched address cycles then a three-cycle data phase
`timescale 1ns/100ps
`default_nettype none
`include "hbr_params.svh"

module hbr_rom_port (
   input  wire logic                 clock,
   input  wire logic                 rst,
   input  wire logic                 req_valid,
   input  wire hbr_pkg::hbr_rom_req_t req,
   output logic                      req_ready,
   output logic                      busy,
   output logic [7:0]                rd_data,
   output logic                      done,
   input  wire logic [7:0]           rom_mux_in,
   output logic [7:0]                rom_mux_addr_data,
   output logic                      rom_mux_oe_n,
   output logic                      rom_addr_latch_strobe,
   input  wire logic                 rom_addr_bit0_in,
   output logic                      rom_addr_bit0_out,
   output logic                      rom_addr_bit0_oe_n,
   output logic                      rom_chip_enable_n,
   output logic                      card_signalling_select_n
);

   typedef enum logic [2:0] {HBR_STRAP, HBR_IDLE, HBR_ADR1, HBR_ADR2, HBR_DATA} hbr_rom_st_t;

   hbr_rom_st_t           st_ff, nxt_st;
   hbr_pkg::hbr_rom_req_t rq_ff, nxt_rq;
   logic [1:0]            cnt_ff, nxt_cnt;
   logic [7:0]            mux_ff, nxt_mux, rd_ff, nxt_rd;
   logic                  moe_ff, nxt_moe, stb_ff, nxt_stb, b0_ff, nxt_b0, b0oe_ff, nxt_b0oe;
   logic                  ce_ff, nxt_ce, done_ff, nxt_done, strap_ff, nxt_strap;

   // ****************************************
   // sequencer
   // ****************************************
   always_comb begin
      nxt_st    = st_ff;
      nxt_rq    = rq_ff;
      nxt_cnt   = cnt_ff;
      nxt_mux   = mux_ff;
      nxt_moe   = moe_ff;
      nxt_stb   = stb_ff;
      nxt_b0    = b0_ff;
      nxt_b0oe  = b0oe_ff;
      nxt_ce    = ce_ff;
      nxt_rd    = rd_ff;
      nxt_done  = 1'b0;
      nxt_strap = strap_ff;
      unique case (st_ff)
         HBR_STRAP: begin
            // pin released since reset, so the strap level is settled
            nxt_strap = rom_addr_bit0_in;
            nxt_b0oe  = 1'b0;
            nxt_st    = HBR_IDLE;
         end
         HBR_IDLE: if (req_valid) begin
            nxt_rq  = req;
            nxt_mux = {req.addr[7:2], req.write, ~req.write};
            nxt_moe = 1'b0;
            nxt_stb = 1'b1;
            nxt_b0  = req.addr[16];
            nxt_st  = HBR_ADR1;
         end
         HBR_ADR1: begin
            nxt_mux = rq_ff.addr[15:8];
            nxt_b0  = rq_ff.addr[17];
            nxt_st  = HBR_ADR2;
         end
         HBR_ADR2: begin
            // both latches loaded before the chip is selected
            nxt_stb = rq_ff.addr[1];
            nxt_b0  = rq_ff.addr[0];
            nxt_ce  = 1'b0;
            nxt_mux = rq_ff.wdata;
            nxt_moe = ~rq_ff.write;
            nxt_cnt = 2'h0;
            nxt_st  = HBR_DATA;
         end
         HBR_DATA: begin
            nxt_cnt = cnt_ff + 2'h1;
            if (cnt_ff == `HBR_ROM_DATA_CYC - 2'h1) begin
               if (!rq_ff.write) begin
                  nxt_rd = rom_mux_in;
               end
               nxt_done = 1'b1;
               nxt_ce   = 1'b1;
               nxt_moe  = 1'b0;
               nxt_stb  = 1'b0;
               nxt_st   = HBR_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         st_ff    <= HBR_STRAP;
         rq_ff    <= '0;
         cnt_ff   <= 2'h0;
         mux_ff   <= `HBR_ROM_MUX_RST;
         moe_ff   <= 1'b1;
         stb_ff   <= 1'b0;
         b0_ff    <= 1'b1;
         b0oe_ff  <= 1'b1;
         ce_ff    <= 1'b1;
         rd_ff    <= 8'h00;
         done_ff  <= 1'b0;
         strap_ff <= 1'b1;
      end else begin
         st_ff    <= nxt_st;
         rq_ff    <= nxt_rq;
         cnt_ff   <= nxt_cnt;
         mux_ff   <= nxt_mux;
         moe_ff   <= nxt_moe;
         stb_ff   <= nxt_stb;
         b0_ff    <= nxt_b0;
         b0oe_ff  <= nxt_b0oe;
         ce_ff    <= nxt_ce;
         rd_ff    <= nxt_rd;
         done_ff  <= nxt_done;
         strap_ff <= nxt_strap;
      end
   end

   assign req_ready                = (st_ff == HBR_IDLE);
   assign busy                     = (st_ff != HBR_IDLE);
   assign rd_data                  = rd_ff;
   assign done                     = done_ff;
   assign rom_mux_addr_data        = mux_ff;
   assign rom_mux_oe_n             = moe_ff;
   assign rom_addr_latch_strobe    = stb_ff;
   assign rom_addr_bit0_out        = b0_ff;
   assign rom_addr_bit0_oe_n       = b0oe_ff;
   assign rom_chip_enable_n        = ce_ff;
   assign card_signalling_select_n = strap_ff;

   // ****************************************
   // checks
   // ****************************************
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);

   a_first_addr_cycle: assert property (st_ff == HBR_ADR1 |-> stb_ff && ce_ff && !moe_ff
      && mux_ff == {rq_ff.addr[7:2], rq_ff.write, ~rq_ff.write} && b0_ff == rq_ff.addr[16])
      else $error("first rom address cycle wrong");
   a_second_addr_cycle: assert property (st_ff == HBR_ADR1 |=> stb_ff
      && mux_ff == rq_ff.addr[15:8] && b0_ff == rq_ff.addr[17])
      else $error("second rom address cycle wrong");
   a_ce_after_latch: assert property ($fell(ce_ff) |-> $past(stb_ff, 1) && $past(stb_ff, 2)
      && $past(st_ff, 2) == HBR_ADR1)
      else $error("chip enable before both address cycles");
   a_ce_only_data: assert property (!ce_ff |-> st_ff == HBR_DATA)
      else $error("chip enable outside data cycle");
   a_strap_held: assert property (st_ff != HBR_STRAP |=> $stable(strap_ff))
      else $error("signalling strap changed after sampling");

   c_rom_read: cover property (st_ff == HBR_DATA && !rq_ff.write ##[1:4] done_ff);
endmodule // hbr_rom_port

`default_nettype wire

/* File: tb/hbr_far_model.sv */
// far side model: host bridge target with arbiter, and a byte-wide boot rom
`timescale 1ns/100ps
`default_nettype none

module hbr_far_model (
   input  wire logic        clock,
   input  wire logic        rst,
   input  wire logic        respond,
   input  wire logic        slow,
   input  wire logic        pci_req_n,
   input  wire logic        pci_frame_n_out,
   input  wire logic        pci_irdy_n_out,
   input  wire logic        pci_ctl_oe_n,
   input  wire logic        pci_ad_oe_n,
   input  wire logic        rom_chip_enable_n,
   input  wire logic        rom_mux_oe_n,
   output logic             pci_gnt_n,
   output logic             pci_trdy_n,
   output logic             pci_devsel_n,
   output logic [31:0]      pci_ad_in,
   output logic [7:0]       rom_mux_in
);
   // ****************************************
   // target and rom lines
   // ****************************************
   logic        act_ff;
   logic        stall_ff;
   logic        sel;
   logic [7:0]  beat_ff;
   logic [7:0]  rlast_ff;
   logic [31:0] last_ff;

   assign sel = respond && act_ff && !pci_ctl_oe_n;
   assign pci_devsel_n = !sel;
   assign pci_trdy_n = !(sel && !stall_ff);
   // released lines toggle so a stale value never looks valid
   assign pci_ad_in = (sel && pci_ad_oe_n) ? 32'h1122_3344 + {24'h0, beat_ff} : ~last_ff;
   assign rom_mux_in = (!rom_chip_enable_n && rom_mux_oe_n) ? 8'h5a : ~rlast_ff;

   always_ff @(posedge clock) begin
      last_ff <= pci_ad_in;
      rlast_ff <= rom_mux_in;
      if (rst) begin
         act_ff <= 1'b0;
         stall_ff <= 1'b0;
         beat_ff <= 8'h00;
         pci_gnt_n <= 1'b1;
      end else begin
         pci_gnt_n <= pci_req_n;
         stall_ff <= slow ? !stall_ff : 1'b0;
         if (!pci_ctl_oe_n && !pci_frame_n_out) act_ff <= 1'b1;
         else if (pci_frame_n_out && pci_irdy_n_out) act_ff <= 1'b0;
         if (!act_ff) beat_ff <= 8'h00;
         else if (!pci_irdy_n_out && !pci_trdy_n) beat_ff <= beat_ff + 8'h01;
      end
   end
endmodule // hbr_far_model
`default_nettype wire

/* File: tb/tb_top.sv */
// self-checking bench for the host bus master and boot rom port
`timescale 1ns/100ps
`default_nettype none
`include "hbr_params.svh"

module tb_top;
   // ****************************************
   // signals
   // ****************************************
   logic        clock = 0, rst = 1, xfer_valid = 0, rom_req_valid = 0;
   logic        respond = 1, slow = 0, host_on = 1, strap = 1, prev_idle = 1;
   hbr_pkg::hbr_xfer_t    xfer = '0;
   hbr_pkg::hbr_rom_req_t rom_req = '0;
   logic [31:0] wr_data, pci_ad_in, pci_ad_out, rd_data;
   logic [7:0]  widx = 0, rom_mux_in, rom_mux_addr_data, rom_rd_data;
   logic [3:0]  pci_cbe_n_out;
   logic        xfer_ready, wr_take, rd_valid, xfer_done, xfer_abort, rom_req_ready, rom_done;
   logic        pci_ad_oe_n, pci_cbe_oe_n, pci_frame_n_out, pci_irdy_n_out, pci_ctl_oe_n;
   logic        pci_trdy_n, pci_devsel_n, pci_req_n, pci_gnt_n, clkrun_out, clkrun_oe_n;
   logic        rom_mux_oe_n, rom_addr_latch_strobe, rom_addr_bit0_out, rom_addr_bit0_oe_n;
   logic        rom_chip_enable_n, card_signalling_select_n, clkrun_in_n, rom_addr_bit0_in;
   int          errors = 0, comparisons = 0;
   logic [31:0] aq[$], cq[$], bq[$], bcq[$], rq[$];

   assign clkrun_in_n = !(host_on || (!clkrun_oe_n && !clkrun_out));
   assign rom_addr_bit0_in = rom_addr_bit0_oe_n ? strap : rom_addr_bit0_out;
   assign wr_data = 32'hc0de_0000 + {24'h0, widx};

   hbr_host_bus dut (.*);
   hbr_far_model far (.*);

   always #50 clock = ~clock;

   // ****************************************
   // bus monitor and helpers
   // ****************************************
   always @(posedge clock) begin
      prev_idle <= pci_ctl_oe_n || pci_frame_n_out;
      if (!pci_ctl_oe_n && !pci_frame_n_out && prev_idle) begin
         aq.push_back(pci_ad_out);
         cq.push_back({28'h0, pci_cbe_n_out});
      end
      if (!pci_ctl_oe_n && !pci_irdy_n_out && !pci_trdy_n && !pci_devsel_n) begin
         bq.push_back(pci_ad_out);
         bcq.push_back({28'h0, pci_cbe_n_out});
      end
      if (rd_valid) rq.push_back(rd_data);
      if (xfer_valid && xfer_ready) widx <= 8'h00;
      else if (wr_take) widx <= widx + 8'h01;
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         errors++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   function automatic logic [31:0] sw(input logic [31:0] w, input logic big);
      return big ? {w[7:0], w[15:8], w[23:16], w[31:24]} : w;
   endfunction

   task automatic conclude;
      $display("errors=%0d comparisons=%0d", errors, comparisons);
      if (errors == 0 && comparisons > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask

   // ****************************************
   // scenarios
   // ****************************************
   task automatic do_reset(input logic s);
      @(posedge clock);
      strap <= s;
      rst <= 1'b1;
      repeat (10) @(posedge clock);
      rst <= 1'b0;
      repeat (3) @(negedge clock);
      chk({card_signalling_select_n, rom_chip_enable_n, pci_req_n, pci_ctl_oe_n, pci_ad_oe_n},
          {s, 4'hf});
   endtask

   // two-beat burst; ok low means the target never claims it
   task automatic bus_op(input logic wr, big, ok, sl, input logic [3:0] be);
      int n;
      logic [3:0] eb;
      n = 0;
      eb = big ? {be[0], be[1], be[2], be[3]} : be;
      aq.delete();
      cq.delete();
      bq.delete();
      bcq.delete();
      rq.delete();
      @(posedge clock);
      respond <= ok;
      slow <= sl;
      xfer_valid <= 1'b1;
      xfer <= '{addr: 32'h8000_0040, write: wr, len: 8'h02, be: be, big_endian: big};
      do @(posedge clock); while (xfer_ready !== 1'b1);
      xfer_valid <= 1'b0;
      while (xfer_done !== 1'b1 && xfer_abort !== 1'b1 && n < 60) begin
         @(negedge clock);
         n++;
      end
      chk(xfer_abort, !ok);
      @(negedge clock);
      chk(aq.size(), 1);
      chk(aq[0], 32'h8000_0040);
      chk(cq[0], wr ? `HBR_CMD_MEM_WR : `HBR_CMD_MEM_RD);
      chk(bq.size(), ok ? 2 : 0);
      for (int i = 0; i < bq.size(); i++) begin
         chk(bcq[i], {28'h0, ~eb});
         if (wr) chk(bq[i], sw(32'hc0de_0000 + i, big));
         else chk(rq[i], sw(32'h1122_3344 + i, big));
      end
   endtask

   task automatic rom_op(input logic [17:0] a, input logic w);
      @(posedge clock);
      rom_req_valid <= 1'b1;
      rom_req <= '{addr: a, write: w, wdata: 8'h3c};
      do @(posedge clock); while (rom_req_ready !== 1'b1);
      rom_req_valid <= 1'b0;
      @(negedge clock);
      chk(rom_mux_addr_data, {a[7:2], w, !w});
      chk({rom_addr_latch_strobe, rom_chip_enable_n, rom_addr_bit0_oe_n}, 3'b110);
      chk(rom_addr_bit0_out, a[16]);
      @(negedge clock);
      chk({rom_mux_addr_data, rom_addr_bit0_out}, {a[15:8], a[17]});
      chk(rom_chip_enable_n, 1'b1);
      @(negedge clock);
      chk({rom_chip_enable_n, rom_addr_latch_strobe, rom_addr_bit0_out, clkrun_oe_n},
          {1'b0, a[1], a[0], 1'b0});
      if (w) chk({rom_mux_oe_n, rom_mux_addr_data}, {1'b0, 8'h3c});
      repeat (3) @(negedge clock);
      chk({rom_done, rom_chip_enable_n, clkrun_oe_n}, 3'b110);
      if (!w) chk(rom_rd_data, 8'h5a);
   endtask

   initial begin
      do_reset(1'b1);
      bus_op(1'b1, 1'b0, 1'b1, 1'b1, 4'h3);
      bus_op(1'b0, 1'b1, 1'b1, 1'b0, 4'hc);
      bus_op(1'b1, 1'b1, 1'b1, 1'b0, 4'h9);
      bus_op(1'b1, 1'b0, 1'b0, 1'b0, 4'hf);
      @(posedge clock);
      host_on <= 1'b0;
      rom_op(18'h2_a5b5, 1'b0);
      rom_op(18'h1_3c4a, 1'b1);
      repeat (4) @(negedge clock);
      chk(clkrun_oe_n, 1'b1);
      @(posedge clock);
      host_on <= 1'b1;
      do_reset(1'b0);
      conclude;
   end

   // the full run needs about a hundred cycles; this is fifty times that
   initial begin
      repeat (5000) @(posedge clock);
      errors++;
      conclude;
   end
endmodule // tb_top
`default_nettype wire
